// ==== include/sovw_params.svh ====
// constants for the sanitize overwrite command block
`ifndef SOVW_PARAMS_SVH
`define SOVW_PARAMS_SVH

// ****************************************
// command codes
// ****************************************
`define SOVW_OPC_SANITIZE 8'hb4
`define SOVW_FEAT_STATUS 16'h0000
`define SOVW_FEAT_OVERWRITE 16'h0014
`define SOVW_FEAT_FREEZE 16'h0020

// ****************************************
// field positions
// ****************************************
`define SOVW_SC_INVERT 7
`define SOVW_SC_FMODE 4
`define SOVW_SC_COUNT_HI 3
`define SOVW_RSP_DONE_OK 15
`define SOVW_RSP_IN_PROG 14
`define SOVW_RSP_FROZEN 13
`define SOVW_ERR_ABORT 2
`define SOVW_STS_READY 6
`define SOVW_STS_SEEK_DONE 4
`define SOVW_STS_ERROR 0

// ****************************************
// values and reset values
// ****************************************
`define SOVW_PASSES_ZERO 5'h10
`define SOVW_PROGRESS_IDLE 16'hffff
`define SOVW_RSN_UNREPORTED 8'h00
`define SOVW_RSN_NOT_SANITIZED 8'h01
`define SOVW_RSN_BAD_FEATURE 8'h02
`define SOVW_RSN_FROZEN 8'h03
`define SOVW_RST_BYTE 8'h00
`define SOVW_RST_WORD 16'h0000
`define SOVW_STRAP_WAIT 2'h2

`endif

// ==== include/sovw_pkg.sv ====
// types for the sanitize overwrite command block
package sovw_pkg;

  typedef enum logic [2:0] {
    sanitize_idle_state = 3'b000,
    sanitize_frozen_state = 3'b001,
    sanitize_running_state = 3'b010,
    sanitize_failed_state = 3'b011,
    sanitize_succeeded_state = 3'b100
  } sovw_san_state_t;

  // task-file bytes written by the host
  typedef struct packed {
    logic [7:0] opcode;
    logic [15:0] feature;
    logic [7:0] count_cur;
    logic [7:0] lba_low_cur;
    logic [7:0] lba_low_prev;
    logic [7:0] lba_mid_cur;
    logic [7:0] lba_high_cur;
  } sovw_cmd_t;

  // task-file bytes returned at completion
  typedef struct packed {
    logic [7:0] command_error_flags;
    logic [7:0] device_condition_flags;
    logic [15:0] count;
    logic [7:0] lba_mid;
    logic [7:0] lba_low;
  } sovw_resp_t;

  typedef struct packed {
    logic valid;
    logic [47:0] lba;
    logic [31:0] pattern;
  } sovw_media_wr_t;

endpackage : sovw_pkg

// ==== rtl/sovw_pass_engine.sv ====
// overwrite pass engine: walks every sector once per pass
`timescale 1ns/10ps
`include "sovw_params.svh"

module sovw_pass_engine #(
  parameter int LBA_BITS = 20
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic [4:0] pass_total,
  input wire logic invert,
  input wire logic [31:0] pattern,
  input wire logic wr_done,
  input wire logic wr_fail,
  output sovw_pkg::sovw_media_wr_t wr,
  output logic busy,
  output logic finished,
  output logic failed,
  output logic [15:0] progress
);

  if (LBA_BITS < 1 || LBA_BITS > 47)
  begin : g_bad_lba
    $error("sovw_pass_engine: LBA_BITS out of range");
  end

  localparam int AW = LBA_BITS + 17;

  typedef struct packed {
    logic busy;
    logic wr_valid;
    logic done;
    logic fail;
    logic [LBA_BITS-1:0] lba;
    logic [4:0] pass;
    logic [4:0] total;
    logic [31:0] pat;
    logic invert;
    logic [AW-1:0] acc;
  } sovw_eng_state_t;

  sovw_eng_state_t st;
  sovw_eng_state_t next_st;

  // floor(65536 / n): progress step per sector, so the sum over
  // every write of every pass lands on full scale for a power-of-two n, just under it otherwise
  function automatic logic [16:0] sovw_recip(input logic [4:0] n);
    case (n)
      5'd1: sovw_recip = 17'h10000;
      5'd2: sovw_recip = 17'h08000;
      5'd3: sovw_recip = 17'h05555;
      5'd4: sovw_recip = 17'h04000;
      5'd5: sovw_recip = 17'h03333;
      5'd6: sovw_recip = 17'h02aaa;
      5'd7: sovw_recip = 17'h02492;
      5'd8: sovw_recip = 17'h02000;
      5'd9: sovw_recip = 17'h01c71;
      5'd10: sovw_recip = 17'h01999;
      5'd11: sovw_recip = 17'h01745;
      5'd12: sovw_recip = 17'h01555;
      5'd13: sovw_recip = 17'h013b1;
      5'd14: sovw_recip = 17'h01249;
      5'd15: sovw_recip = 17'h01111;
      default: sovw_recip = 17'h01000;
    endcase
  endfunction : sovw_recip

  always_comb
  begin
    next_st = st;
    next_st.done = 1'b0;
    if (start && !st.busy)
    begin
      next_st.busy = 1'b1;
      next_st.wr_valid = 1'b1;
      next_st.fail = 1'b0;
      next_st.lba = '0;
      next_st.pass = 5'h00;
      next_st.total = pass_total;
      next_st.pat = pattern;
      next_st.invert = invert;
      next_st.acc = '0;
    end
    else if (st.busy && st.wr_valid && wr_done)
    begin
      next_st.fail = st.fail | wr_fail; // R19
      next_st.acc = st.acc + AW'(sovw_recip(st.total));
      if (st.lba == {LBA_BITS{1'b1}})
      begin
        next_st.lba = '0;
        next_st.pass = st.pass + 5'h01;
        if (st.pass + 5'h01 == st.total)
        begin
          next_st.busy = 1'b0;
          next_st.wr_valid = 1'b0;
          next_st.done = 1'b1;
        end
        else if (st.invert)
          next_st.pat = ~st.pat; // R4
      end
      else
        next_st.lba = st.lba + 1'b1; // R2 R7
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign wr.valid = st.wr_valid;
  assign wr.lba = 48'(st.lba);
  assign wr.pattern = st.pat;
  assign busy = st.busy;
  assign finished = st.done;
  assign failed = st.fail;
  // at the very end a power-of-two pass count makes the sum touch full scale; clamp it
  assign progress = st.acc[AW-1] ? 16'hffff : st.acc[AW-2 -: 16]; // R15

endmodule : sovw_pass_engine

// ==== rtl/sovw_top.sv ====
// sanitize command interpreter with overwrite, freeze lock and status
// Functional notes
// [R1] overwrite needs opcode B4h and feature 0014h
// [R2] accepted overwrite fills whole user area
// [R3] accept only when supported and idle/failed/succeeded
// [R4] sector-count bit 7 inverts pattern between passes
// [R5] bits 3:0 give passes, zero means sixteen
// [R6] pattern bytes from four task-file address bytes
// [R7] pattern written to every affected sector
// [R8] sector-count bit 4 captured as failure-exit option
// [R9] option one: status query leaves failed state
// [R10] option zero: failed aborts option-one commands
// [R11] abort option-one overwrite after option-zero failure
// [R12] bit 15 success flag, kept across power-on
// [R13] bit 14 shows operation in progress
// [R14] bit 13 shows frozen state
// [R15] progress numerator over 65536 in two bytes
// [R16] progress all ones when not running
// [R17] abort flag after freeze lock since power-on
// [R18] error reason code in sector number byte
// [R19] success means every written block is readable
// [R20] frozen aborts all but status until reset
// [R21] completion: busy, fault, corrected clear; error on abort
// [R22] running on start, failed/succeeded on end
`timescale 1ns/10ps
`include "sovw_params.svh"

module sovw_top #(
  parameter int LBA_BITS = 20,
  parameter bit SANITIZE_SUPPORTED = 1'b1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input sovw_pkg::sovw_cmd_t cmd,
  output logic resp_valid,
  output sovw_pkg::sovw_resp_t resp,
  output sovw_pkg::sovw_media_wr_t media_wr,
  input wire logic media_wr_done,
  input wire logic media_wr_fail,
  input wire logic nv_done_ok_in,
  output logic nv_done_ok_out,
  output sovw_pkg::sovw_san_state_t san_state
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (LBA_BITS < 1 || LBA_BITS > 47)
  begin : g_bad_lba
    $error("sovw_top: LBA_BITS out of range");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    sovw_pkg::sovw_san_state_t san;
    logic failure_exit_option;
    logic freeze_seen;
    logic done_ok;
    logic resp_valid;
    sovw_pkg::sovw_resp_t resp;
    logic strap_meta;
    logic strap_sync;
    logic [1:0] strap_wait;
    logic start;
    logic [4:0] passes;
    logic invert;
    logic [31:0] pattern;
  } sovw_top_state_t;

  sovw_top_state_t st;
  sovw_top_state_t next_st;

  logic eng_busy;
  logic eng_finished;
  logic eng_failed;
  logic [15:0] eng_progress;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [4:0] sovw_pass_count(input logic [7:0] count_byte);
    if (count_byte[`SOVW_SC_COUNT_HI:0] == 4'h0)
      sovw_pass_count = `SOVW_PASSES_ZERO; // R5
    else
      sovw_pass_count = {1'b0, count_byte[`SOVW_SC_COUNT_HI:0]}; // R5
  endfunction : sovw_pass_count

  function automatic logic sovw_may_start(input sovw_pkg::sovw_san_state_t s);
    sovw_may_start = (s == sovw_pkg::sanitize_idle_state) ||
                     (s == sovw_pkg::sanitize_failed_state) ||
                     (s == sovw_pkg::sanitize_succeeded_state);
  endfunction : sovw_may_start

  function automatic sovw_pkg::sovw_resp_t sovw_answer(
    input sovw_pkg::sovw_san_state_t s,
    input logic ok,
    input logic [15:0] prog,
    input logic abort,
    input logic freeze_seen,
    input logic [7:0] reason
  );
    sovw_pkg::sovw_resp_t r;
    logic [15:0] p;
    r = '0;
    p = (s == sovw_pkg::sanitize_running_state) ? prog : `SOVW_PROGRESS_IDLE; // R15 R16
    r.count[`SOVW_RSP_DONE_OK] = ok; // R12
    r.count[`SOVW_RSP_IN_PROG] = (s == sovw_pkg::sanitize_running_state); // R13
    r.count[`SOVW_RSP_FROZEN] = (s == sovw_pkg::sanitize_frozen_state); // R14
    r.lba_mid = p[15:8]; // R15
    r.lba_low = p[7:0]; // R15
    // busy, fault and corrected stay zero in every completion
    r.device_condition_flags[`SOVW_STS_READY] = 1'b1; // R21
    r.device_condition_flags[`SOVW_STS_SEEK_DONE] = 1'b1; // R21
    r.device_condition_flags[`SOVW_STS_ERROR] = abort; // R21
    r.command_error_flags[`SOVW_ERR_ABORT] = abort | (freeze_seen & abort); // R17
    if (abort)
      r.lba_low = reason; // R18
    sovw_answer = r;
  endfunction : sovw_answer

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb
  begin
    logic abort;
    logic [7:0] reason;
    logic fm_new;
    logic [15:0] prog;
    abort = 1'b0;
    reason = `SOVW_RSN_UNREPORTED;
    fm_new = cmd.count_cur[`SOVW_SC_FMODE];
    // the engine keeps its old sum until its start pulse lands, one cycle
    // after acceptance; show zero until it is really counting
    prog = eng_busy ? eng_progress : 16'h0000; // R15
    next_st = st;
    next_st.resp_valid = 1'b0;
    next_st.start = 1'b0;

    // strap catch: the synced level is taken once, after release,
    // so the success flag reappears across a power-on reset
    next_st.strap_meta = nv_done_ok_in;
    next_st.strap_sync = st.strap_meta;
    if (st.strap_wait != 2'h3)
    begin
      next_st.strap_wait = st.strap_wait + 2'h1;
      if (st.strap_wait == `SOVW_STRAP_WAIT)
        next_st.done_ok = st.strap_sync; // R12
    end

    // end of the background operation
    if (eng_finished && st.san == sovw_pkg::sanitize_running_state)
    begin
      if (eng_failed)
      begin
        next_st.san = sovw_pkg::sanitize_failed_state; // R22
        next_st.done_ok = 1'b0;
      end
      else
      begin
        next_st.san = sovw_pkg::sanitize_succeeded_state; // R22 R19
        next_st.done_ok = 1'b1; // R12
      end
    end

    // host command; non-sanitize opcodes are not this block's
    if (cmd_valid && cmd.opcode == `SOVW_OPC_SANITIZE)
    begin
      next_st.resp_valid = 1'b1;
      case (cmd.feature)
        `SOVW_FEAT_OVERWRITE: // R1
        begin
          if (!SANITIZE_SUPPORTED)
          begin
            abort = 1'b1; // R3
            reason = `SOVW_RSN_BAD_FEATURE;
          end
          else if (st.freeze_seen || st.san == sovw_pkg::sanitize_frozen_state)
          begin
            abort = 1'b1; // R17 R20
            reason = `SOVW_RSN_FROZEN;
          end
          else if (!sovw_may_start(st.san))
            abort = 1'b1; // R3
          else if (st.san == sovw_pkg::sanitize_failed_state &&
                   !st.failure_exit_option && fm_new)
            abort = 1'b1; // R10 R11
          else
          begin
            next_st.san = sovw_pkg::sanitize_running_state; // R22
            next_st.done_ok = 1'b0; // R12
            next_st.failure_exit_option = fm_new; // R8
            next_st.start = 1'b1; // R2
            next_st.passes = sovw_pass_count(cmd.count_cur);
            next_st.invert = cmd.count_cur[`SOVW_SC_INVERT]; // R4
            next_st.pattern = {cmd.lba_low_prev, cmd.lba_high_cur,
                               cmd.lba_mid_cur, cmd.lba_low_cur}; // R6
          end
        end
        `SOVW_FEAT_FREEZE:
        begin
          if (!SANITIZE_SUPPORTED)
          begin
            abort = 1'b1;
            reason = `SOVW_RSN_BAD_FEATURE;
          end
          else if (st.san == sovw_pkg::sanitize_frozen_state)
          begin
            abort = 1'b1; // R20
            reason = `SOVW_RSN_FROZEN;
          end
          else if (!sovw_may_start(st.san))
            abort = 1'b1;
          else
          begin
            next_st.san = sovw_pkg::sanitize_frozen_state; // R20
            next_st.freeze_seen = 1'b1; // R17
          end
        end
        `SOVW_FEAT_STATUS:
        begin
          if (!SANITIZE_SUPPORTED)
          begin
            abort = 1'b1;
            reason = `SOVW_RSN_BAD_FEATURE;
          end
          else if (st.san == sovw_pkg::sanitize_failed_state &&
                   st.failure_exit_option)
            next_st.san = sovw_pkg::sanitize_idle_state; // R9
        end
        default:
        begin
          abort = 1'b1; // R1
          reason = `SOVW_RSN_BAD_FEATURE; // R18
        end
      endcase
      // the answer shows the state as it stands after this command
      next_st.resp = sovw_answer(next_st.san, next_st.done_ok, prog,
                                 abort, st.freeze_seen, reason);
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // reset also takes the frozen state back to idle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0; // R20
      st.san <= sovw_pkg::sanitize_idle_state;
      st.resp.lba_mid <= `SOVW_RST_BYTE;
      st.resp.count <= `SOVW_RST_WORD;
    end
    else
      st <= next_st;
  end

  // ****************************************
  // pass engine
  // ****************************************
  // user area is taken as 2**LBA_BITS sectors; a drive of other size
  // needs a limit compare in place of the all-ones wrap
  sovw_pass_engine #(
    .LBA_BITS(LBA_BITS)
  ) u_engine (
    .clk(clk),
    .arst_n(arst_n),
    .start(st.start),
    .pass_total(st.passes),
    .invert(st.invert),
    .pattern(st.pattern),
    .wr_done(media_wr_done),
    .wr_fail(media_wr_fail),
    .wr(media_wr),
    .busy(eng_busy),
    .finished(eng_finished),
    .failed(eng_failed),
    .progress(eng_progress)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign resp_valid = st.resp_valid;
  assign resp = st.resp;
  assign nv_done_ok_out = st.done_ok; // R12
  assign san_state = st.san;

endmodule : sovw_top

// ==== test/sovw_media_model.sv ====
// media model answering sector writes
`timescale 1ns/10ps
module sovw_media_model #(
  parameter int LBA_BITS = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  input sovw_pkg::sovw_media_wr_t wr,
  input wire logic [3:0] slow,
  input wire logic fail_en,
  output logic done,
  output logic fail
);
  logic [31:0] mem [2**LBA_BITS];
  int writes;
  logic [3:0] cnt;
  // qualifier means nothing without done, so it wanders there
  assign fail = done ? fail_en : cnt[0];
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      done <= 1'b0;
      cnt <= 4'h0;
    end
    else if (wr.valid && done)
    begin
      mem[wr.lba[LBA_BITS-1:0]] <= wr.pattern;
      writes <= writes + 1;
      cnt <= 4'h0;
      done <= slow == 4'h0;
    end
    else
    begin
      done <= wr.valid && cnt >= slow;
      cnt <= cnt + 4'h1;
    end
endmodule : sovw_media_model

// ==== test/sovw_props.sv ====
// checker for the sanitize command block
`timescale 1ns/10ps
`include "sovw_params.svh"
module sovw_props (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input sovw_pkg::sovw_cmd_t cmd,
  input wire logic resp_valid,
  input sovw_pkg::sovw_resp_t resp,
  input sovw_pkg::sovw_media_wr_t media_wr,
  input wire logic media_wr_done,
  input wire logic media_wr_fail,
  input wire logic nv_done_ok_in,
  input wire logic nv_done_ok_out,
  input sovw_pkg::sovw_san_state_t san_state
);
  // ****************
  // properties
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic take;
  logic ow;
  logic abort_error_flag;
  logic run;
  assign take = cmd_valid && cmd.opcode == `SOVW_OPC_SANITIZE;
  assign ow = take && cmd.feature == `SOVW_FEAT_OVERWRITE;
  assign abort_error_flag = resp.command_error_flags[`SOVW_ERR_ABORT];
  assign run = san_state == sovw_pkg::sanitize_running_state;
  // engine shows the first sector one cycle after the answer and still holds it two cycles after
  sequence ow_start;
    run && resp.count[14] ##2 media_wr.valid && media_wr.lba == 48'h0;
  endsequence
  take_resp_a: assert property (take |=> resp_valid)
    else $error("no answer to a sanitize command");
  other_quiet_a: assert property (!take |=> !resp_valid)
    else $error("answer without a sanitize command");
  idle_start_a: assert property (ow && san_state == sovw_pkg::sanitize_idle_state |=> ow_start)
    else $error("overwrite from idle did not start");
  busy_refuse_a: assert property (ow && run |=> abort_error_flag && resp.lba_low == 8'h00)
    else $error("overwrite taken while running");
  frozen_refuse_a: assert property (ow && san_state == sovw_pkg::sanitize_frozen_state
    |=> abort_error_flag && resp.lba_low == `SOVW_RSN_FROZEN)
    else $error("overwrite taken while frozen");
  bad_feat_a: assert property (take
    && !(cmd.feature inside {16'h0000, 16'h0014, 16'h0020})
    |=> abort_error_flag && resp.lba_low == `SOVW_RSN_BAD_FEATURE)
    else $error("unknown feature not refused");
  run_flag_a: assert property (resp_valid |-> resp.count[14] == run)
    else $error("progress flag wrong");
  frozen_flag_a: assert property (resp_valid
    |-> resp.count[13] == (san_state == sovw_pkg::sanitize_frozen_state))
    else $error("frozen flag wrong");
  idle_prog_a: assert property (resp_valid && !abort_error_flag && !run
    |-> {resp.lba_mid, resp.lba_low} == `SOVW_PROGRESS_IDLE)
    else $error("idle progress not all ones");
  clean_sts_a: assert property (resp_valid
    |-> resp.device_condition_flags[7] == 1'b0
    && resp.device_condition_flags[5] == 1'b0 && resp.device_condition_flags[2] == 1'b0
    && resp.device_condition_flags[0] == abort_error_flag)
    else $error("completion status wrong");
  wr_hold_a: assert property (media_wr.valid && !media_wr_done
    |=> media_wr.valid && $stable(media_wr.lba) && $stable(media_wr.pattern))
    else $error("sector write dropped before done");
  ok_kept_a: assert property (san_state == sovw_pkg::sanitize_succeeded_state
    |-> nv_done_ok_out)
    else $error("success flag not stored");
endmodule : sovw_props

bind sovw_top sovw_props u_props (.clk, .arst_n, .cmd_valid, .cmd, .resp_valid, .resp,
  .media_wr, .media_wr_done, .media_wr_fail, .nv_done_ok_in, .nv_done_ok_out, .san_state);

// ==== test/sovw_top_tb.sv ====
// testbench for the sanitize command block
`timescale 1ns/10ps
`include "sovw_params.svh"
module sovw_top_tb;
  localparam int LB = 2;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic fail_en = 1'b0;
  logic nv_in = 1'b0;
  logic [3:0] slow = 4'h0;
  sovw_pkg::sovw_cmd_t cmd = '0;
  sovw_pkg::sovw_resp_t resp;
  sovw_pkg::sovw_resp_t rsp;
  sovw_pkg::sovw_media_wr_t wr;
  sovw_pkg::sovw_san_state_t st;
  logic resp_valid, done, fail, nv_out, got;
  int failures = 0;
  int checked = 0;
  int base;
  initial forever #5 clk = ~clk;
  sovw_top #(.LBA_BITS(LB)) u_dut (.clk, .arst_n, .cmd_valid, .cmd, .resp_valid, .resp,
    .media_wr(wr), .media_wr_done(done), .media_wr_fail(fail), .nv_done_ok_in(nv_in),
    .nv_done_ok_out(nv_out), .san_state(st));
  sovw_media_model #(.LBA_BITS(LB)) u_media (.clk, .arst_n, .wr, .slow, .fail_en, .done,
    .fail);
  // ****************
  // tasks
  // ****************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic stop_test();
    if (failures == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic send(input logic [7:0] op, input logic [15:0] ft, input logic [7:0] sc,
    input logic [31:0] pat);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = '{op, ft, sc, pat[7:0], pat[31:24], pat[15:8], pat[23:16]};
    @(negedge clk);
    cmd_valid = 1'b0;
    got = resp_valid;
    rsp = resp;
  endtask : send
  task automatic refused(input logic [7:0] rsn);
    chk("answered", got, 1'b1);
    chk("error", {rsp.command_error_flags[2], rsp.device_condition_flags[0]}, 2'h3);
    chk("reason", rsp.lba_low, rsn);
  endtask : refused
  task automatic run_ow(input logic [7:0] sc, input logic [31:0] pat, input logic fen,
    input logic [3:0] sl, input logic poke);
    int n;
    fail_en = fen;
    slow = sl;
    base = u_media.writes;
    send(`SOVW_OPC_SANITIZE, `SOVW_FEAT_OVERWRITE, sc, pat);
    chk("started", {got, rsp.command_error_flags[2], rsp.count[14]}, 3'h5);
    chk("progress", {rsp.lba_mid, rsp.lba_low}, 16'h0000);
    if (poke)
    begin
      send(`SOVW_OPC_SANITIZE, `SOVW_FEAT_OVERWRITE, sc, pat);
      refused(`SOVW_RSN_UNREPORTED);
    end
    n = 0;
    while (st === sovw_pkg::sanitize_running_state && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    n = (sc[3:0] == 4'h0) ? 16 : sc[3:0];
    chk("writes", u_media.writes - base, n << LB);
    chk("end state", st, fen ? sovw_pkg::sanitize_failed_state
      : sovw_pkg::sanitize_succeeded_state);
    if (!fen)
      for (int i = 0; i < 2**LB; i++)
        chk("sector", u_media.mem[i], (sc[7] && !n[0]) ? ~pat : pat);
  endtask : run_ow
  // ****************
  // sequence
  // ****************
  initial
  begin
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    send(`SOVW_OPC_SANITIZE, `SOVW_FEAT_STATUS, 8'h00, 32'h0);
    chk("idle status", {got, rsp.device_condition_flags, rsp.count[15:13]}, 12'ha80);
    chk("idle progress", {rsp.lba_mid, rsp.lba_low}, 16'hffff);
    send(`SOVW_OPC_SANITIZE, 16'h0015, 8'h01, 32'h0);
    refused(`SOVW_RSN_BAD_FEATURE);
    send(8'hb5, `SOVW_FEAT_OVERWRITE, 8'h01, 32'h0);
    chk("ignored", got, 1'b0);
    run_ow(8'h82, 32'h1234_5678, 1'b0, 4'h0, 1'b0);
    chk("kept flag", nv_out, 1'b1);
    run_ow(8'h00, 32'ha5a5_0f0f, 1'b0, 4'h2, 1'b1);
    run_ow(8'h13, 32'h0000_00ff, 1'b1, 4'h0, 1'b0);
    send(`SOVW_OPC_SANITIZE, `SOVW_FEAT_STATUS, 8'h00, 32'h0);
    chk("left failed", st, sovw_pkg::sanitize_idle_state);
    run_ow(8'h01, 32'h00ff_0000, 1'b1, 4'h1, 1'b0);
    send(`SOVW_OPC_SANITIZE, `SOVW_FEAT_OVERWRITE, 8'h11, 32'h0);
    refused(`SOVW_RSN_UNREPORTED);
    send(`SOVW_OPC_SANITIZE, `SOVW_FEAT_STATUS, 8'h00, 32'h0);
    chk("stays failed", st, sovw_pkg::sanitize_failed_state);
    run_ow(8'h81, 32'h0f1e_2d3c, 1'b0, 4'h0, 1'b0);
    send(`SOVW_OPC_SANITIZE, `SOVW_FEAT_FREEZE, 8'h00, 32'h0);
    chk("frozen", {rsp.command_error_flags[2], rsp.count[13]}, 2'h1);
    send(`SOVW_OPC_SANITIZE, `SOVW_FEAT_OVERWRITE, 8'h01, 32'h0);
    refused(`SOVW_RSN_FROZEN);
    send(`SOVW_OPC_SANITIZE, `SOVW_FEAT_FREEZE, 8'h00, 32'h0);
    refused(`SOVW_RSN_FROZEN);
    send(`SOVW_OPC_SANITIZE, `SOVW_FEAT_STATUS, 8'h00, 32'h0);
    chk("status frozen", rsp.command_error_flags[2], 1'b0);
    // store keeps the success flag across the power cycle
    nv_in = nv_out;
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("after reset", st, sovw_pkg::sanitize_idle_state);
    send(`SOVW_OPC_SANITIZE, `SOVW_FEAT_STATUS, 8'h00, 32'h0);
    chk("flag kept", rsp.count[15], 1'b1);
    stop_test();
  end
  initial
  begin
    // whole run is a few hundred cycles
    #200000;
    failures++;
    stop_test();
  end
endmodule : sovw_top_tb
